// ### common/ident_software_tx_enable_regs.vh
// register offsets, field positions, reset values and fixed codes of the
// identification and transmit-enable register group; include by bare name
`ifndef IDENT_SOFTWARE_TX_ENABLE_REGS_VH
`define IDENT_SOFTWARE_TX_ENABLE_REGS_VH

`define ADDR_DEVICE_CLASS 12'h003
`define ADDR_PRODUCT_ID_LO 12'h004
`define ADDR_PRODUCT_ID_HI 12'h005
`define ADDR_SILICON_REV 12'h006
`define ADDR_MAKER_ID_LO 12'h00c
`define ADDR_MAKER_ID_HI 12'h00d
`define ADDR_PIN_BEHAVIOUR 12'h020
`define ADDR_TX_SOURCE 12'h021
`define ADDR_SW_TX_ENABLE 12'h022
`define ADDR_OPERATING_MODE 12'h002

`define RST_DEVICE_CLASS_RSVD 4'h0
`define RST_PIN_BEHAVIOUR 8'h00
`define RST_TX_SOURCE 8'h0f
`define RST_SW_TX_ENABLE 8'h00
`define RST_OPERATING_MODE 8'h00

`define BIT_SLEEP_FULL_DOWN 0
`define BIT_SW_SEL_A 0
`define BIT_SW_SEL_B 1
`define BIT_ALARM_MUTE_CHAN_A 2
`define BIT_ALARM_MUTE_CHAN_B 3
`define BIT_SW_TX_A 0
`define BIT_SW_TX_B 1

`define MODE_NORMAL 2'h0
`define MODE_SLEEP 2'h2
`define MODE_POWER_DOWN 2'h3

`endif

// ### src/pin_sync.v
// three-flop synchroniser for one asynchronous pin
// a new level is accepted only once the second and third stages agree
`timescale 1ns/10ps
module pin_sync (
    clk,
    rst,
    pin,
    level
);
    input wire clk;
    input wire rst;
    input wire pin;
    output reg level;

    reg s1_reg;
    reg s2_reg;
    reg s3_reg;

    always @(posedge clk) begin
        if (rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            level <= 1'b0;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                level <= s3_reg;
            end
        end
    end
endmodule // pin_sync

// ### src/chan_gate.v
// per-channel transmit enable and alarm mute decision, registered
// assumes alarm and mute mask come from logic on the same clock
`timescale 1ns/10ps
module chan_gate #(
    parameter ALARM_W = 8
) (
    clk,
    rst,
    sw_select,
    sw_enable,
    pin_enable,
    automute,
    alarms,
    mute_mask,
    asleep,
    tx_enable,
    muted
);
    input wire clk;
    input wire rst;
    input wire sw_select;
    input wire sw_enable;
    input wire pin_enable;
    input wire automute;
    input wire [ALARM_W-1:0] alarms;
    input wire [ALARM_W-1:0] mute_mask;
    input wire asleep;
    output reg tx_enable;
    output reg muted;

    wire mute_next;
    assign mute_next = automute & (|(alarms & ~mute_mask));

    always @(posedge clk) begin
        if (rst) begin
            tx_enable <= 1'b0;
            muted <= 1'b0;
        end else begin
            tx_enable <= ~asleep & (sw_select ? sw_enable : pin_enable);
            muted <= mute_next;
        end
    end
endmodule // chan_gate

// ### src/ident_and_tx_enable_regs.v
// identification and transmit-enable register group of a dual-channel dac
// assumes a serial-interface front end on clk presenting byte accesses:
// wr_en/rd_en one-cycle strobes with addr and wr_data; rd_data valid next cycle
`timescale 1ns/10ps
`include "ident_software_tx_enable_regs.vh"
module ident_and_tx_enable_regs #(
    parameter ALARM_W = 8,
    parameter [3:0] CLASS_CODE = 4'h9,
    parameter [15:0] PRODUCT_CODE = 16'h1234,
    parameter [7:0] REVISION_CODE = 8'h01,
    parameter [15:0] MAKER_CODE = 16'h5a5a
) (
    clk,
    rst,
    wr_en,
    rd_en,
    addr,
    wr_data,
    rd_data,
    rd_valid,
    sleep_pin,
    txenable_pin,
    alarms,
    mute_mask,
    operating_mode,
    effective_mode,
    sleep_chan_a,
    sleep_chan_b,
    sleep_clock_rx,
    sleep_bandgap,
    sleep_lvds_rx,
    sleep_temp_sensor,
    full_power_down,
    tx_enable_chan_a,
    tx_enable_chan_b,
    mute_chan_a,
    mute_chan_b
);
    // arbitrary neutral identity values above; replace per product
    input wire clk;
    input wire rst;
    input wire wr_en;
    input wire rd_en;
    input wire [11:0] addr;
    input wire [7:0] wr_data;
    output reg [7:0] rd_data;
    output reg rd_valid;
    input wire sleep_pin;
    input wire txenable_pin;
    input wire [ALARM_W-1:0] alarms;
    input wire [ALARM_W-1:0] mute_mask;
    output reg [1:0] operating_mode;
    output reg [1:0] effective_mode;
    output reg sleep_chan_a;
    output reg sleep_chan_b;
    output reg sleep_clock_rx;
    output reg sleep_bandgap;
    output reg sleep_lvds_rx;
    output reg sleep_temp_sensor;
    output reg full_power_down;
    output wire tx_enable_chan_a;
    output wire tx_enable_chan_b;
    output wire mute_chan_a;
    output wire mute_chan_b;

    reg [3:0] class_rsvd_reg;
    reg [7:0] pin_behaviour_config_reg;
    reg [7:0] tx_source_and_automute_reg;
    reg [7:0] software_tx_enable_reg;
    reg [7:0] mode_cfg_reg;
    reg [7:0] rd_next;
    reg [1:0] mode_next;
    wire sleep_level;
    wire software_tx_enable_level;
    wire sleep_full_down_sel;
    wire sw_control_select_chan_a;
    wire sw_control_select_chan_b;
    wire alarm_mute_chan_a;
    wire alarm_mute_chan_b;
    wire sw_transmit_chan_a;
    wire sw_transmit_chan_b;
    wire asleep_next;

    // modes 2 and 3 both park the low-power domains; mode 1 keeps running
    function mode_sleeps;
        input [1:0] mode;
        begin
            mode_sleeps = (mode == `MODE_SLEEP) || (mode == `MODE_POWER_DOWN);
        end
    endfunction

    // halves of the 16-bit identity words on the byte-wide bus
    function [7:0] pick_byte;
        input [15:0] word;
        input upper;
        begin
            pick_byte = upper ? word[15:8] : word[7:0];
        end
    endfunction

    // named views of the control fields used by the mode logic and the two channel gates
    assign sleep_full_down_sel = pin_behaviour_config_reg[`BIT_SLEEP_FULL_DOWN];
    assign sw_control_select_chan_a = tx_source_and_automute_reg[`BIT_SW_SEL_A];
    assign sw_control_select_chan_b = tx_source_and_automute_reg[`BIT_SW_SEL_B];
    assign alarm_mute_chan_a = tx_source_and_automute_reg[`BIT_ALARM_MUTE_CHAN_A];
    assign alarm_mute_chan_b = tx_source_and_automute_reg[`BIT_ALARM_MUTE_CHAN_B];
    assign sw_transmit_chan_a = software_tx_enable_reg[`BIT_SW_TX_A];
    assign sw_transmit_chan_b = software_tx_enable_reg[`BIT_SW_TX_B];
    // sleeping domains also hold both transmitters off
    assign asleep_next = mode_sleeps(mode_next);

    // both pins come from outside clk; each adds four edges of latency
    pin_sync u_sleep_sync (
        .clk(clk),
        .rst(rst),
        .pin(sleep_pin),
        .level(sleep_level)
    );

    pin_sync u_software_tx_enable_sync (
        .clk(clk),
        .rst(rst),
        .pin(txenable_pin),
        .level(software_tx_enable_level)
    );

    // register writes; read-only codes have no storage so writes fall away
    always @(posedge clk) begin
        if (rst) begin
            class_rsvd_reg <= `RST_DEVICE_CLASS_RSVD;
            pin_behaviour_config_reg <= `RST_PIN_BEHAVIOUR;
            tx_source_and_automute_reg <= `RST_TX_SOURCE;
            software_tx_enable_reg <= `RST_SW_TX_ENABLE;
            mode_cfg_reg <= `RST_OPERATING_MODE;
        end else if (wr_en) begin
            case (addr)
                `ADDR_DEVICE_CLASS: begin
                    // only the reserved nibble has storage; the class code stays fixed
                    class_rsvd_reg <= wr_data[7:4];
                end
                `ADDR_PIN_BEHAVIOUR: begin
                    pin_behaviour_config_reg <= wr_data;
                end
                `ADDR_TX_SOURCE: begin
                    tx_source_and_automute_reg <= wr_data;
                end
                `ADDR_SW_TX_ENABLE: begin
                    software_tx_enable_reg <= wr_data;
                end
                `ADDR_OPERATING_MODE: begin
                    mode_cfg_reg <= wr_data;
                end
                default: begin
                end
            endcase
        end
    end

    // read mux; unmapped addresses return zero so a stray read is harmless
    always @* begin
        case (addr)
            `ADDR_DEVICE_CLASS: begin
                rd_next = {class_rsvd_reg, CLASS_CODE};
            end
            `ADDR_PRODUCT_ID_LO: begin
                rd_next = pick_byte(PRODUCT_CODE, 1'b0);
            end
            `ADDR_PRODUCT_ID_HI: begin
                rd_next = pick_byte(PRODUCT_CODE, 1'b1);
            end
            `ADDR_SILICON_REV: begin
                rd_next = REVISION_CODE;
            end
            `ADDR_MAKER_ID_LO: begin
                rd_next = pick_byte(MAKER_CODE, 1'b0);
            end
            `ADDR_MAKER_ID_HI: begin
                rd_next = pick_byte(MAKER_CODE, 1'b1);
            end
            `ADDR_PIN_BEHAVIOUR: begin
                rd_next = pin_behaviour_config_reg;
            end
            `ADDR_TX_SOURCE: begin
                rd_next = tx_source_and_automute_reg;
            end
            `ADDR_SW_TX_ENABLE: begin
                rd_next = software_tx_enable_reg;
            end
            `ADDR_OPERATING_MODE: begin
                rd_next = mode_cfg_reg;
            end
            default: begin
                rd_next = 8'h00;
            end
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
        end else begin
            // rd_data holds the last byte read until the next read strobe
            rd_valid <= rd_en;
            if (rd_en) begin
                rd_data <= rd_next;
            end
        end
    end

    // the pin overrides behaviour only; mode_cfg_reg itself is never touched
    always @* begin
        if (sleep_level) begin
            if (sleep_full_down_sel) begin
                mode_next = `MODE_POWER_DOWN;
            end else begin
                mode_next = `MODE_SLEEP;
            end
        end else begin
            mode_next = mode_cfg_reg[1:0];
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            operating_mode <= `MODE_NORMAL;
            effective_mode <= `MODE_NORMAL;
            full_power_down <= 1'b0;
        end else begin
            operating_mode <= mode_cfg_reg[1:0];
            effective_mode <= mode_next;
            full_power_down <= (mode_next == `MODE_POWER_DOWN);
        end
    end

    // power-down implies every sleep domain as well
    always @(posedge clk) begin
        if (rst) begin
            sleep_chan_a <= 1'b0;
            sleep_chan_b <= 1'b0;
            sleep_clock_rx <= 1'b0;
            sleep_bandgap <= 1'b0;
            sleep_lvds_rx <= 1'b0;
            sleep_temp_sensor <= 1'b0;
        end else begin
            sleep_chan_a <= asleep_next;
            sleep_chan_b <= asleep_next;
            sleep_clock_rx <= asleep_next;
            sleep_bandgap <= asleep_next;
            sleep_lvds_rx <= asleep_next;
            sleep_temp_sensor <= asleep_next;
        end
    end

    // both gates share the synchronised pin; software bits are per channel
    chan_gate #(
        .ALARM_W(ALARM_W)
    ) u_gate_a (
        .clk(clk),
        .rst(rst),
        .sw_select(sw_control_select_chan_a),
        .sw_enable(sw_transmit_chan_a),
        .pin_enable(software_tx_enable_level),
        .automute(alarm_mute_chan_a),
        .alarms(alarms),
        .mute_mask(mute_mask),
        .asleep(asleep_next),
        .tx_enable(tx_enable_chan_a),
        .muted(mute_chan_a)
    );

    chan_gate #(
        .ALARM_W(ALARM_W)
    ) u_gate_b (
        .clk(clk),
        .rst(rst),
        .sw_select(sw_control_select_chan_b),
        .sw_enable(sw_transmit_chan_b),
        .pin_enable(software_tx_enable_level),
        .automute(alarm_mute_chan_b),
        .alarms(alarms),
        .mute_mask(mute_mask),
        .asleep(asleep_next),
        .tx_enable(tx_enable_chan_b),
        .muted(mute_chan_b)
    );
endmodule // ident_and_tx_enable_regs

// ### tb/regs_sva.sv
// checker for the id and transmit-enable register group
// assumes the top module's byte bus and pins, bound below by name
`timescale 1ns/10ps
module regs_sva #(
    parameter ALARM_W = 8,
    parameter [3:0] CLASS_CODE = 4'h9,
    parameter [15:0] PRODUCT_CODE = 16'h1234,
    parameter [7:0] REVISION_CODE = 8'h01,
    parameter [15:0] MAKER_CODE = 16'h5a5a
) (
    input wire clk,
    input wire rst,
    input wire rd_en,
    input wire [11:0] addr,
    input wire [7:0] rd_data,
    input wire rd_valid,
    input wire sleep_pin,
    input wire [ALARM_W-1:0] alarms,
    input wire [ALARM_W-1:0] mute_mask,
    input wire [1:0] operating_mode,
    input wire [1:0] effective_mode,
    input wire sleep_chan_a,
    input wire full_power_down,
    input wire tx_enable_chan_a,
    input wire tx_enable_chan_b,
    input wire mute_chan_a,
    input wire mute_chan_b
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence rd_at(logic [11:0] a);
        rd_en && addr == a;
    endsequence
    // eight edges cover the pin synchroniser with margin
    sequence pin_held;
        sleep_pin [*8];
    endsequence
    class_code_a: assert property (rd_at(12'h003) |=> rd_valid && rd_data[3:0] == CLASS_CODE)
        else $error("device class code wrong");
    product_lo_a: assert property (rd_at(12'h004) |=> rd_data == PRODUCT_CODE[7:0])
        else $error("product identifier wrong");
    revision_code_a: assert property (rd_at(12'h006) |=> rd_data == REVISION_CODE)
        else $error("silicon revision wrong");
    maker_lo_a: assert property (rd_at(12'h00c) |=> rd_data == MAKER_CODE[7:0])
        else $error("maker identifier wrong");
    pin_sleep_a: assert property (pin_held |-> effective_mode[1])
        else $error("sleep pin not applied");
    power_down_a: assert property ($stable(effective_mode) |->
        full_power_down == (effective_mode == 2'h3))
        else $error("power down flag wrong");
    mode_follow_a: assert property ((!sleep_pin && $stable(operating_mode)) [*8] |->
        effective_mode == operating_mode)
        else $error("applied mode differs from stored");
    block_sleep_a: assert property ($stable(effective_mode) |->
        sleep_chan_a == effective_mode[1])
        else $error("channel sleep wrong");
    tx_forced_a: assert property (effective_mode[1] [*3] |->
        !tx_enable_chan_a && !tx_enable_chan_b)
        else $error("transmit on while asleep");
    no_alarm_a: assert property ((alarms & ~mute_mask) == 0 |=>
        !mute_chan_a && !mute_chan_b)
        else $error("mute without alarm");
endmodule // regs_sva

bind ident_and_tx_enable_regs regs_sva #(.ALARM_W(ALARM_W), .CLASS_CODE(CLASS_CODE),
    .PRODUCT_CODE(PRODUCT_CODE), .REVISION_CODE(REVISION_CODE), .MAKER_CODE(MAKER_CODE))
    sva_u (.clk(clk), .rst(rst), .rd_en(rd_en), .addr(addr), .rd_data(rd_data),
    .rd_valid(rd_valid), .sleep_pin(sleep_pin), .alarms(alarms), .mute_mask(mute_mask),
    .operating_mode(operating_mode), .effective_mode(effective_mode),
    .sleep_chan_a(sleep_chan_a), .full_power_down(full_power_down),
    .tx_enable_chan_a(tx_enable_chan_a), .tx_enable_chan_b(tx_enable_chan_b),
    .mute_chan_a(mute_chan_a), .mute_chan_b(mute_chan_b));

// ### tb/host_model.sv
// host side of the byte register bus: one strobe per byte access
// assumes reads answer one cycle after the strobe edge
`timescale 1ns/10ps
module host_model (
    input wire clk,
    output reg wr_en,
    output reg rd_en,
    output reg [11:0] addr,
    output reg [7:0] wr_data,
    input wire [7:0] rd_data,
    input wire rd_valid
);
    initial begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 12'h000;
        wr_data = 8'h00;
    end
    task wr(input [11:0] a, input [7:0] d);
        begin
            @(negedge clk);
            wr_en = 1'b1;
            addr = a;
            wr_data = d;
            @(negedge clk);
            wr_en = 1'b0;
            // idle data flips so a stale byte is never mistaken for valid
            wr_data = ~d;
        end
    endtask
    task rd(input [11:0] a, output [7:0] d, output v);
        begin
            @(negedge clk);
            rd_en = 1'b1;
            addr = a;
            @(negedge clk);
            rd_en = 1'b0;
            d = rd_data;
            v = rd_valid;
        end
    endtask
endmodule // host_model

// ### tb/ident_and_tx_enable_regs_test.sv
// self-checking bench for the id and transmit-enable register group
// assumes host_model for bus cycles and the bound regs_sva checker
`timescale 1ns/10ps
module ident_and_tx_enable_regs_test;
    localparam [3:0] CLS = 4'h9; // arbitrary value
    localparam [15:0] PRD = 16'h1234; // arbitrary value
    localparam [7:0] REV = 8'h01; // arbitrary value
    localparam [15:0] MKR = 16'h5a5a; // arbitrary value
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg sleep_pin = 1'b0;
    reg software_tx_enable_pin = 1'b0;
    reg [7:0] alarms = 8'h00;
    reg [7:0] mask = 8'h00;
    wire wr_en, rd_en, rd_valid, txa, txb, mta, mtb;
    wire [11:0] addr;
    wire [7:0] wr_data, rd_data;
    wire [1:0] op_mode, eff;
    wire [6:0] slp;
    integer n_fail = 0;
    integer num_checks = 0;
    integer cyc = 0;
    integer i;
    host_model host_u (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid));
    ident_and_tx_enable_regs #(.CLASS_CODE(CLS), .PRODUCT_CODE(PRD), .REVISION_CODE(REV),
        .MAKER_CODE(MKR)) dut_u (.clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en),
        .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
        .sleep_pin(sleep_pin), .txenable_pin(software_tx_enable_pin), .alarms(alarms), .mute_mask(mask),
        .operating_mode(op_mode), .effective_mode(eff), .sleep_chan_a(slp[0]),
        .sleep_chan_b(slp[1]), .sleep_clock_rx(slp[2]), .sleep_bandgap(slp[3]),
        .sleep_lvds_rx(slp[4]), .sleep_temp_sensor(slp[5]), .full_power_down(slp[6]),
        .tx_enable_chan_a(txa), .tx_enable_chan_b(txb), .mute_chan_a(mta), .mute_chan_b(mtb));
    task c8(input [7:0] g, input [7:0] e);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                n_fail = n_fail + 1;
                $display("Error at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task rc(input [11:0] a, input [7:0] e);
        reg [7:0] d;
        reg v;
        begin
            host_u.rd(a, d, v);
            c8({7'h00, v}, 8'h01);
            c8(d, e);
        end
    endtask
    task tick(input integer n);
        repeat (n) @(negedge clk);
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", num_checks, n_fail);
            if (n_fail == 0 && num_checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    initial forever #2.5 clk = ~clk;
    // the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            n_fail = n_fail + 1;
            final_report;
        end
    end
    initial begin
        tick(20);
        rst = 1'b0;
        rc(12'h021, 8'h0f);
        rc(12'h022, 8'h00);
        rc(12'h003, {4'h0, CLS});
        rc(12'h005, PRD[15:8]);
        rc(12'h00d, MKR[15:8]);
        rc(12'h0ff, 8'h00);
        $display("test reset values done");
        for (i = 3; i < 14; i = i + 1)
            host_u.wr(i[11:0], 8'hff);
        rc(12'h003, {4'hf, CLS});
        rc(12'h004, PRD[7:0]);
        rc(12'h005, PRD[15:8]);
        rc(12'h006, REV);
        rc(12'h00c, MKR[7:0]);
        rc(12'h00d, MKR[15:8]);
        $display("test read-only done");
        host_u.wr(12'h022, 8'h01);
        software_tx_enable_pin = 1'b1;
        tick(8);
        c8({6'h00, txb, txa}, 8'h01);
        host_u.wr(12'h022, 8'h02);
        tick(3);
        c8({6'h00, txb, txa}, 8'h02);
        host_u.wr(12'h021, 8'h0c);
        tick(3);
        c8({6'h00, txb, txa}, 8'h03);
        software_tx_enable_pin = 1'b0;
        tick(8);
        c8({6'h00, txb, txa}, 8'h00);
        $display("test enable source done");
        alarms = 8'h10;
        tick(3);
        c8({6'h00, mtb, mta}, 8'h03);
        mask = 8'h10;
        tick(3);
        c8({6'h00, mtb, mta}, 8'h00);
        mask = 8'h00;
        host_u.wr(12'h021, 8'h04);
        tick(3);
        c8({6'h00, mtb, mta}, 8'h01);
        host_u.wr(12'h021, 8'h08);
        tick(3);
        c8({6'h00, mtb, mta}, 8'h02);
        alarms = 8'h00;
        $display("test auto-mute done");
        host_u.wr(12'h002, 8'h01);
        host_u.wr(12'h021, 8'h03);
        host_u.wr(12'h022, 8'h03);
        sleep_pin = 1'b1;
        tick(8);
        c8({6'h00, eff}, 8'h02);
        c8({1'b0, slp}, 8'h3f);
        c8({6'h00, txb, txa}, 8'h00);
        c8({6'h00, op_mode}, 8'h01);
        rc(12'h002, 8'h01);
        host_u.wr(12'h020, 8'h01);
        tick(3);
        c8({6'h00, eff}, 8'h03);
        c8({1'b0, slp}, 8'h7f);
        sleep_pin = 1'b0;
        tick(8);
        c8({6'h00, eff}, 8'h01);
        c8({6'h00, txb, txa}, 8'h03);
        $display("test sleep pin done");
        final_report;
    end
endmodule // ident_and_tx_enable_regs_test
